//--- core/sector_protect_pkg.sv
// Shared constants and carrier types for the sector protection block
package sector_protect_pkg;

   // Register byte offsets (low address byte decoded)
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_CMD      = 8'h04;
   localparam logic [7:0] OFS_OPT_DATA = 8'h08;
   localparam logic [7:0] OFS_OPTIONS  = 8'h0c;
   localparam logic [7:0] OFS_PWD_LO   = 8'h10;
   localparam logic [7:0] OFS_PWD_HI   = 8'h14;
   localparam logic [7:0] OFS_KEY_LO   = 8'h18;
   localparam logic [7:0] OFS_KEY_HI   = 8'h1c;
   localparam logic [7:0] OFS_CONFIG   = 8'h20;
   localparam logic [7:0] OFS_SEC_SEL  = 8'h24;
   localparam logic [7:0] OFS_SEC_BITS = 8'h28;

   // Command codes written to the command register, bits 7:0
   localparam logic [7:0] CMD_PPB_PROGRAM = 8'h01;
   localparam logic [7:0] CMD_PPB_ERASE   = 8'h02;
   localparam logic [7:0] CMD_LOCK_CLEAR  = 8'h03;
   localparam logic [7:0] CMD_UNLOCK      = 8'h04;
   localparam logic [7:0] CMD_OPT_PROGRAM = 8'h05;
   localparam logic [7:0] CMD_PWD_PROGRAM = 8'h06;
   localparam logic [7:0] CMD_DYB_WRITE   = 8'h07;
   localparam logic [7:0] CMD_CFG_WRITE   = 8'h08;
   localparam logic [7:0] CMD_ERR_CLEAR   = 8'h09;

   // Command register fields
   localparam int CMD_VAL_BIT = 8;
   localparam int CMD_SEC_LSB = 16;

   // Status register bits
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam int ST_RDPW_BIT = 2;
   localparam int ST_REJ_BIT  = 3;
   localparam int ST_FAIL_BIT = 4;
   localparam int ST_INIT_BIT = 5;

   // Protection option bits, a bit is selected when programmed to 0
   localparam int OPT_W         = 16;
   localparam int OPT_PERMANENT = 0;
   localparam int OPT_PERSIST   = 1;
   localparam int OPT_PASSWORD  = 2;
   localparam int OPT_OTP       = 3;
   localparam int OPT_DYB_PWRUP = 4;
   localparam int OPT_READ_PW   = 5;
   localparam logic [OPT_W-1:0] OPT_RESET = 16'hffff;

   // Configuration bit and geometry
   localparam int CFG_TB_BIT = 5;
   localparam int SECTOR_LSB = 18;
   localparam int PWD_W      = 64;

   // Busy times in cycles of hclk
   localparam int PROG_CYCLES_DEF  = 32;
   localparam int ERASE_CYCLES_DEF = 256;

   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {ACC_READ, ACC_PROG, ACC_ERASE, ACC_NONE} acc_kind_e;

   typedef struct packed {
      logic        valid;
      acc_kind_e   kind;
      logic [31:0] addr;
   } arr_req_s;

   typedef struct packed {
      logic        valid;
      logic        grant;
      logic [31:0] addr;
   } arr_resp_s;

endpackage : sector_protect_pkg

//--- core/access_filter.sv
// Array access filter: grants or denies array accesses and redirects reads
`timescale 1ns/100ps
module access_filter
   import sector_protect_pkg::*;
#(
   parameter int ADDR_W = 26
)
(
   input  wire logic                              hclk,
   input  wire logic                              hresetn,
   input  wire arr_req_s                          req,
   input  wire logic [(1<<(ADDR_W-SECTOR_LSB))-1:0] persistent_protect_bit,
   input  wire logic [(1<<(ADDR_W-SECTOR_LSB))-1:0] volatile_sector_guard,
   input  wire logic                              rdpw_mode,
   input  wire logic                              top_bottom,
   output arr_resp_s                              resp
);
   localparam int SEC_W = ADDR_W - SECTOR_LSB;

   logic [SEC_W-1:0] sec;
   logic [SEC_W-1:0] alias_sec;
   logic             grant_nxt;
   logic [31:0]      addr_nxt;
   arr_resp_s        resp_r;

   // Sector of the request and the one sector left readable in read-password mode
   assign sec       = req.addr[SECTOR_LSB +: SEC_W];
   assign alias_sec = top_bottom ? '0 : '1;                           // [R14]

   // Decision; a zero in either protection bit protects the sector
   always_comb
   begin
      grant_nxt = 1'b0;
      addr_nxt  = req.addr;
      unique case (req.kind)
         ACC_READ:
         begin
            grant_nxt = 1'b1;
            if (rdpw_mode)
            begin
               // Whatever sector is asked for, the readable one answers
               addr_nxt = '0;
               addr_nxt[SECTOR_LSB +: SEC_W]  = alias_sec;            // [R13] [R15] [R21]
               addr_nxt[SECTOR_LSB-1:0]       = req.addr[SECTOR_LSB-1:0];
            end
         end
         ACC_PROG, ACC_ERASE:
            grant_nxt = !rdpw_mode && persistent_protect_bit[sec] && volatile_sector_guard[sec];           // [R01] [R13] [R22] [R23]
         ACC_NONE:
            grant_nxt = 1'b0;
      endcase
   end

   // Answer is registered, one cycle after the request
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         resp_r <= '0;
      else
      begin
         resp_r.valid <= req.valid;
         resp_r.grant <= req.valid && grant_nxt;
         resp_r.addr  <= addr_nxt;
      end

   assign resp = resp_r;

endmodule : access_filter

//--- core/sector_protect.sv
// Sector protection controller with AHB-Lite register slave
//
// Behaviour
// R01 - Program and erase are refused on a sector whose persistent bit is 0.
// R02 - Persistent bits program one by one; erase always clears the whole group.
// R03 - Status stays readable while a persistent bit program or erase runs.
// R04 - Permanent option rejects persistent bit changes and options register writes.
// R05 - Lock flag 0 freezes persistent bits; lock flag 1 lets them change.
// R06 - Lock clear command drops the flag; only reset raises it again. The code also raises it on a successful password unlock.
// R07 - Without password scheme, reset leaves the lock flag at 1.
// R08 - Host clears the lock only after setting all persistent bits.
// R09 - With password scheme, reset leaves the lock flag at 0.
// R10 - Full 64-bit password unlock sets the lock flag only on success.
// R11 - Password option enables the scheme and freezes the options register.
// R12 - Host programs a password before picking a password scheme.
// R13 - Read-password mode blocks array access except one readable end sector.
// R14 - Top/bottom 0 picks the top sector, 1 picks the bottom sector.
// R15 - Reads into the protected array alias to the readable sector.
// R16 - Before unlock in read-password mode only a short command list works.
// R17 - One-time option permanently rejects the persistent bit group erase.
// R18 - Host selects persistent configuration or password scheme, never both.
// R19 - Host selects read-password together with the password scheme.
// R20 - Once password scheme is selected the stored password reads as zero.
// R21 - Read-password plus password selected redirects addresses until unlock.
// R22 - Read-password mode rejects every memory program and register write; the code still takes unlock, error clear and staging word writes.
// R23 - Volatile guard counts only when persistent bit is 1; either 0 protects.
// R24 - Persistent configuration option freezes config, options and password.
// R25 - A wrong password changes neither lock flag nor read-password mode.
`timescale 1ns/100ps
module sector_protect
   import sector_protect_pkg::*;
#(
   parameter int ADDR_W       = 26,
   parameter int PROG_CYCLES  = PROG_CYCLES_DEF,
   parameter int ERASE_CYCLES = ERASE_CYCLES_DEF
)
(
   input  wire logic                              hclk,
   input  wire logic                              hresetn,
   input  wire logic                              hsel,
   input  wire logic [31:0]                       haddr,
   input  wire logic [1:0]                        htrans,
   input  wire logic                              hwrite,
   input  wire logic [2:0]                        hsize,
   input  wire logic [31:0]                       hwdata,
   input  wire logic                              hready,
   output logic                                   hreadyout,
   output logic                                   hresp,
   output logic [31:0]                            hrdata,
   input  wire logic [OPT_W-1:0]                  opt_nv_in,
   input  wire logic [PWD_W-1:0]                  pwd_nv_in,
   input  wire logic [(1<<(ADDR_W-SECTOR_LSB))-1:0] ppb_nv_in,
   output logic [OPT_W-1:0]                       opt_nv_out,
   output logic [PWD_W-1:0]                       pwd_nv_out,
   output logic [(1<<(ADDR_W-SECTOR_LSB))-1:0]    ppb_nv_out,
   input  wire arr_req_s                          arr_req,
   output arr_resp_s                              arr_resp
);
   localparam int SEC_W = ADDR_W - SECTOR_LSB;
   localparam int NSEC  = 1 << SEC_W;

   // Geometry and timer width limits, refused while elaborating
   if (SEC_W < 1 || SEC_W > 16 || ADDR_W > 32)
   begin : g_geom_chk
      $error("sector_protect: ADDR_W must be 19 to 32");
   end
   if (PROG_CYCLES < 1 || PROG_CYCLES > 65535 || ERASE_CYCLES < 1 || ERASE_CYCLES > 65535)
   begin : g_busy_chk
      $error("sector_protect: busy cycle counts must be 1 to 65535");
   end

   typedef enum {ST_INIT, ST_READY, ST_BUSY} state_e;

   state_e            st_r;
   logic [15:0]       cnt_r;
   logic              op_erase_r;
   logic [SEC_W-1:0]  op_sec_r;
   logic              wr_pend_r;
   logic [7:0]        wr_ofs_r;
   logic [31:0]       hrdata_r;
   logic              lock_r;
   logic              rdpw_r;
   logic [OPT_W-1:0]  opt_r;
   logic [OPT_W-1:0]  opt_stage_r;
   logic [PWD_W-1:0]  pwd_r;
   logic [PWD_W-1:0]  pwd_stage_r;
   logic [PWD_W-1:0]  key_r;
   logic              tb_r;
   logic [NSEC-1:0]   ppb_r;
   logic [NSEC-1:0]   dyb_r;
   logic [SEC_W-1:0]  sel_r;
   logic              rej_r;
   logic              fail_r;
   logic              bus_take;
   logic              cmd_go;
   logic [7:0]        cmd_code;
   logic [SEC_W-1:0]  cmd_sec;
   logic              cmd_val;
   logic              cmd_ok;
   logic              busy_done;
   logic              pwd_match;
   logic              sel_perm;
   logic              sel_persist;
   logic              sel_pwd;
   logic              sel_otp;
   logic [31:0]       rd_mux;

   // Data-phase write to one register offset
   function automatic logic wr_hit(input logic pend, input logic [7:0] ofs, input logic [7:0] want);
      wr_hit = pend && (ofs == want);
   endfunction : wr_hit

   // Options are active low: a programmed zero selects the scheme
   assign sel_perm    = !opt_r[OPT_PERMANENT];
   assign sel_persist = !opt_r[OPT_PERSIST];
   assign sel_pwd     = !opt_r[OPT_PASSWORD];
   assign sel_otp     = !opt_r[OPT_OTP];

   // The slave never stretches a transfer and never signals an error
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;
   assign bus_take  = hsel && hready && htrans[1];

   // Command fields taken straight from the write data phase
   assign cmd_go    = wr_hit(wr_pend_r, wr_ofs_r, OFS_CMD);
   assign cmd_code  = hwdata[7:0];
   assign cmd_sec   = hwdata[CMD_SEC_LSB +: SEC_W];
   assign cmd_val   = hwdata[CMD_VAL_BIT];
   assign busy_done = (st_r == ST_BUSY) && (cnt_r == 16'h0000);
   assign pwd_match = (key_r == pwd_r);                               // [R10]

   // Address phase capture; only whole-word writes are kept
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wr_ofs_r  <= 8'h00;
      end
      else
      begin
         wr_pend_r <= bus_take && hwrite && (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h000000);
         wr_ofs_r  <= haddr[7:0];
      end

   // Command acceptance; anything not accepted raises the reject flag
   always_comb
   begin
      cmd_ok = 1'b0;
      if (st_r == ST_READY)
      begin
         case (cmd_code)
            CMD_PPB_PROGRAM: cmd_ok = !sel_perm && lock_r && !rdpw_r;               // [R04] [R05] [R22]
            CMD_PPB_ERASE:   cmd_ok = !sel_perm && !sel_otp && lock_r && !rdpw_r;   // [R04] [R05] [R17]
            CMD_LOCK_CLEAR:  cmd_ok = !rdpw_r;                                      // [R16]
            CMD_UNLOCK:      cmd_ok = sel_pwd;
            CMD_OPT_PROGRAM: cmd_ok = !sel_perm && !sel_pwd && !sel_persist && !rdpw_r; // [R04] [R11] [R24]
            CMD_PWD_PROGRAM: cmd_ok = !sel_persist && !sel_pwd && !rdpw_r;          // [R24] [R22]
            CMD_DYB_WRITE:   cmd_ok = !rdpw_r;                                      // [R16]
            CMD_CFG_WRITE:   cmd_ok = !sel_persist && !rdpw_r;                      // [R24] [R22]
            CMD_ERR_CLEAR:   cmd_ok = 1'b1;
            default:         cmd_ok = 1'b0;
         endcase
      end
      // While busy or initialising cmd_ok stays 0, so every command bounces; reads and staging writes are still served
   end

   // Sequencer: one init cycle after reset, then ready or busy
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         st_r       <= ST_INIT;
         cnt_r      <= 16'h0000;
         op_erase_r <= 1'b0;
         op_sec_r   <= '0;
      end
      else
      begin
         unique case (st_r)
            ST_INIT:
               st_r <= ST_READY;
            ST_READY:
               if (cmd_go && cmd_ok && (cmd_code == CMD_PPB_PROGRAM || cmd_code == CMD_PPB_ERASE))
               begin
                  st_r       <= ST_BUSY;
                  op_erase_r <= (cmd_code == CMD_PPB_ERASE);
                  op_sec_r   <= cmd_sec;
                  cnt_r      <= (cmd_code == CMD_PPB_ERASE) ? 16'(ERASE_CYCLES - 1) : 16'(PROG_CYCLES - 1);
               end
            ST_BUSY:
               if (busy_done)
                  st_r <= ST_READY;
               else
                  cnt_r <= cnt_r - 16'h0001;
         endcase
      end

   // Persistent bits: loaded at init, one bit cleared or the whole group set at completion
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         ppb_r <= '1;
      else if (st_r == ST_INIT)
         ppb_r <= ppb_nv_in;
      else if (busy_done && op_erase_r)
         ppb_r <= '1;                                                 // [R02]
      else if (busy_done)
         ppb_r[op_sec_r] <= 1'b0;                                     // [R02]

   // Lock flag and read-password mode; reset holds the lock flag at 0 and read-password mode off until init decides
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         lock_r <= 1'b0;
         rdpw_r <= 1'b0;
      end
      else if (st_r == ST_INIT)
      begin
         lock_r <= opt_nv_in[OPT_PASSWORD];                           // [R07] [R09]
         rdpw_r <= !opt_nv_in[OPT_READ_PW] && !opt_nv_in[OPT_PASSWORD]; // [R21]
      end
      else if (cmd_go && cmd_ok && cmd_code == CMD_LOCK_CLEAR)
         lock_r <= 1'b0;                                              // [R06]
      else if (cmd_go && cmd_ok && cmd_code == CMD_UNLOCK && pwd_match)
      begin
         lock_r <= 1'b1;                                              // [R10]
         rdpw_r <= 1'b0;                                              // [R21]
      end
      // A failed unlock falls through and leaves both untouched [R25]

   // Options, password and configuration bit; programming only clears option bits
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         opt_r <= OPT_RESET;
         pwd_r <= '1;
         tb_r  <= 1'b0;
      end
      else if (st_r == ST_INIT)
      begin
         opt_r <= opt_nv_in;
         pwd_r <= pwd_nv_in;
      end
      else if (cmd_go && cmd_ok)
      begin
         if (cmd_code == CMD_OPT_PROGRAM)
            opt_r <= opt_r & opt_stage_r;                             // [R11]
         if (cmd_code == CMD_PWD_PROGRAM)
            pwd_r <= pwd_stage_r;
         if (cmd_code == CMD_CFG_WRITE)
            tb_r <= cmd_val;                                          // [R14]
      end

   // Volatile guards; the power-up option starts them all protected
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         dyb_r <= '1;
      else if (st_r == ST_INIT)
         dyb_r <= opt_nv_in[OPT_DYB_PWRUP] ? '1 : '0;
      else if (cmd_go && cmd_ok && cmd_code == CMD_DYB_WRITE)
         dyb_r[cmd_sec] <= cmd_val;

   // Sticky error flags; setting cannot coincide with the clearing command
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         rej_r  <= 1'b0;
         fail_r <= 1'b0;
      end
      else if (cmd_go)
      begin
         if (!cmd_ok)
            rej_r <= 1'b1;                                            // [R16] [R22]
         else if (cmd_code == CMD_ERR_CLEAR)
         begin
            rej_r  <= 1'b0;
            fail_r <= 1'b0;
         end
         else if (cmd_code == CMD_UNLOCK && !pwd_match)
            fail_r <= 1'b1;                                           // [R25]
      end

   // Staging words written by software ahead of the commands that use them
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         opt_stage_r <= OPT_RESET;
         pwd_stage_r <= '1;
         key_r       <= '0;
         sel_r       <= '0;
      end
      else
      begin
         if (wr_hit(wr_pend_r, wr_ofs_r, OFS_OPT_DATA))
            opt_stage_r <= hwdata[OPT_W-1:0];
         if (wr_hit(wr_pend_r, wr_ofs_r, OFS_PWD_LO))
            pwd_stage_r[31:0] <= hwdata;
         if (wr_hit(wr_pend_r, wr_ofs_r, OFS_PWD_HI))
            pwd_stage_r[63:32] <= hwdata;
         if (wr_hit(wr_pend_r, wr_ofs_r, OFS_KEY_LO))
            key_r[31:0] <= hwdata;
         if (wr_hit(wr_pend_r, wr_ofs_r, OFS_KEY_HI))
            key_r[63:32] <= hwdata;
         if (wr_hit(wr_pend_r, wr_ofs_r, OFS_SEC_SEL))
            sel_r <= hwdata[SEC_W-1:0];
      end

   // Read mux, evaluated in the address phase; unmapped and write-only words read zero
   always_comb
   begin
      rd_mux = 32'h00000000;
      if (haddr[31:8] == 24'h000000)
      begin
         case (haddr[7:0])
            OFS_STATUS:
            begin
               rd_mux[ST_BUSY_BIT] = (st_r == ST_BUSY);               // [R03]
               rd_mux[ST_LOCK_BIT] = lock_r;
               rd_mux[ST_RDPW_BIT] = rdpw_r;
               rd_mux[ST_REJ_BIT]  = rej_r;
               rd_mux[ST_FAIL_BIT] = fail_r;
               rd_mux[ST_INIT_BIT] = (st_r == ST_INIT);
            end
            OFS_OPT_DATA: rd_mux[OPT_W-1:0] = opt_stage_r;
            OFS_OPTIONS:  rd_mux[OPT_W-1:0] = opt_r;
            OFS_PWD_LO:   rd_mux = sel_pwd ? 32'h00000000 : pwd_r[31:0];  // [R20]
            OFS_PWD_HI:   rd_mux = sel_pwd ? 32'h00000000 : pwd_r[63:32]; // [R20]
            OFS_CONFIG:   rd_mux[CFG_TB_BIT] = tb_r;
            OFS_SEC_SEL:  rd_mux[SEC_W-1:0] = sel_r;
            OFS_SEC_BITS: rd_mux[1:0] = {dyb_r[sel_r], ppb_r[sel_r]};
            default:      rd_mux = 32'h00000000;
         endcase
      end
   end

   // Read data is latched at the address phase edge so it stands through the data phase
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         hrdata_r <= 32'h00000000;
      else if (bus_take && !hwrite)
         hrdata_r <= rd_mux;

   // Nonvolatile image handed back to the outside store
   assign opt_nv_out = opt_r;
   assign pwd_nv_out = pwd_r;
   assign ppb_nv_out = ppb_r;

   // Array accesses are judged against the live protection state
   access_filter #(
      .ADDR_W     (ADDR_W)
   ) u_filter (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .req        (arr_req),
      .persistent_protect_bit        (ppb_r),
      .volatile_sector_guard        (dyb_r),
      .rdpw_mode  (rdpw_r),
      .top_bottom (tb_r),
      .resp       (arr_resp)
   );

endmodule : sector_protect

//--- verif/host_model.sv
// AHB-Lite master standing in for the host controller
`timescale 1ns/100ps
module host_model
   import sector_protect_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   output logic [31:0]      haddr = '0,
   output logic [1:0]       htrans = '0,
   output logic             hwrite = 1'b0,
   output logic [2:0]       hsize = HSIZE_WORD,
   output logic [31:0]      hwdata = '0
);
   // Single word transfer; each phase is held until ready is seen high
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer
endmodule : host_model

//--- verif/sector_protect_sva.sv
// Port checks for the sector protection block
`timescale 1ns/100ps
module sector_protect_sva
   import sector_protect_pkg::*;
#(
   parameter int ADDR_W = 26
)
(
   input wire logic                                hclk,
   input wire logic                                hresetn,
   input wire logic                                hreadyout,
   input wire logic                                hresp,
   input wire logic [OPT_W-1:0]                    opt_nv_out,
   input wire logic [PWD_W-1:0]                    pwd_nv_out,
   input wire logic [(1<<(ADDR_W-SECTOR_LSB))-1:0] ppb_nv_out,
   input wire arr_req_s                            arr_req,
   input wire arr_resp_s                           arr_resp
);
   localparam int SEC_W = ADDR_W - SECTOR_LSB;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Persistent bit of the sector a request aims at
   logic sec_ppb;
   assign sec_ppb = ppb_nv_out[arr_req.addr[SECTOR_LSB +: SEC_W]];
   sequence wr_req_s;
      arr_req.valid && (arr_req.kind == ACC_PROG || arr_req.kind == ACC_ERASE);
   endsequence
   sequence rd_req_s;
      arr_req.valid && arr_req.kind == ACC_READ;
   endsequence
   status_ready_a: assert property (hreadyout && !hresp)
      else $error("bus stalled");
   prot_block_a: assert property (wr_req_s ##0 !sec_ppb |=> !arr_resp.grant)
      else $error("protected sector granted");
   read_pass_a: assert property (rd_req_s |=> arr_resp.valid && arr_resp.grant)
      else $error("read not granted");
   none_kind_a: assert property (arr_req.kind == ACC_NONE |=> !arr_resp.grant)
      else $error("idle kind granted");
   read_offset_a: assert property (rd_req_s |=> arr_resp.addr[17:0] == $past(arr_req.addr[17:0]))
      else $error("read offset lost");
   perm_freeze_a: assert property (!opt_nv_out[OPT_PERMANENT] |=> $stable(ppb_nv_out) && $stable(opt_nv_out))
      else $error("permanent state changed");
   otp_noerase_a: assert property (!opt_nv_out[OPT_OTP] |=> (ppb_nv_out & ~$past(ppb_nv_out)) == '0)
      else $error("one-time bits erased");
   pwd_freeze_a: assert property (!opt_nv_out[OPT_PASSWORD] |=> $stable(opt_nv_out))
      else $error("options changed");
   persist_freeze_a: assert property (!opt_nv_out[OPT_PERSIST] |=> $stable(opt_nv_out) && $stable(pwd_nv_out))
      else $error("frozen state changed");
endmodule : sector_protect_sva

bind sector_protect sector_protect_sva #(.ADDR_W(ADDR_W)) sva_u (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .opt_nv_out(opt_nv_out), .pwd_nv_out(pwd_nv_out),
   .ppb_nv_out(ppb_nv_out), .arr_req(arr_req), .arr_resp(arr_resp));

//--- verif/sector_protect_bench.sv
// Self-checking bench for the sector protection block
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module sector_protect_bench
   import sector_protect_pkg::*;
;
   localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
   logic             hclk = 1'b0;
   logic             hresetn = 1'b0;
   logic [31:0]      haddr, hwdata, hrdata, s;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   logic             hwrite, hreadyout, hresp;
   logic [OPT_W-1:0] opt_in = OPT_RESET;
   logic [OPT_W-1:0] opt_out;
   logic [PWD_W-1:0] pwd_out;
   logic [255:0]     ppb_out;
   arr_req_s         arr_req = '0;
   arr_resp_s        arr_resp;
   int               fails = 0;
   int               total_checks = 0;

   // 50 MHz clock
   always #10 hclk = ~hclk;

   sector_protect #(.PROG_CYCLES(8), .ERASE_CYCLES(16)) dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .opt_nv_in(opt_in), .pwd_nv_in(PW), .ppb_nv_in({256{1'b1}}), .opt_nv_out(opt_out),
      .pwd_nv_out(pwd_out), .ppb_nv_out(ppb_out), .arr_req, .arr_resp);
   host_model host_u (.hclk, .hreadyout, .hrdata, .haddr, .htrans, .hwrite, .hsize, .hwdata);

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      host_u.xfer(1'b1, {24'h0, a}, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host_u.xfer(1'b0, {24'h0, a}, 32'h0, s);
   endtask : rd
   task automatic cmd(input logic [7:0] c, input logic [7:0] sec);
      wr(OFS_CMD, {8'h0, sec, 8'h0, c});
   endtask : cmd
   // Poll status until the busy flag drops; the watchdog bounds the wait
   task automatic idle();
      do rd(OFS_STATUS); while (s[ST_BUSY_BIT] !== 1'b0);
   endtask : idle
   // Reset with a new stored options image; two spare edges cover the init cycle
   task automatic reboot(input logic [OPT_W-1:0] o);
      opt_in <= o;
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask : reboot
   task automatic arr(input acc_kind_e k, input logic [31:0] a, output arr_resp_s r);
      @(posedge hclk);
      arr_req <= '{1'b1, k, a};
      @(posedge hclk);
      arr_req <= '0;
      #1 r = arr_resp;
   endtask : arr

   task automatic t_lock();
      arr_resp_s r;
      rd(OFS_STATUS);
      `CHK(s[5:0], 6'h02)
      rd(OFS_PWD_LO);
      `CHK(s, PW[31:0])
      cmd(CMD_PPB_PROGRAM, 8'd3);
      rd(OFS_STATUS);
      `CHK(s[ST_BUSY_BIT], 1'b1)
      idle();
      `CHK(ppb_out[4:3], 2'b10)
      arr(ACC_PROG, 32'h3 << SECTOR_LSB, r);
      `CHK(r.grant, 1'b0)
      arr(ACC_ERASE, 32'h4 << SECTOR_LSB, r);
      `CHK(r.grant, 1'b1)
      cmd(CMD_DYB_WRITE, 8'd4);
      arr(ACC_ERASE, 32'h4 << SECTOR_LSB, r);
      `CHK(r.grant, 1'b0)
      wr(OFS_CMD, {23'h0, 1'b1, CMD_CFG_WRITE});
      rd(OFS_CONFIG);
      `CHK(s, 32'h20)
      cmd(CMD_PPB_ERASE, 8'd0);
      idle();
      `CHK(ppb_out, {256{1'b1}})
      cmd(CMD_LOCK_CLEAR, 8'd0);
      cmd(CMD_UNLOCK, 8'd0);
      cmd(CMD_PPB_PROGRAM, 8'd5);
      idle();
      `CHK(ppb_out[5], 1'b1)
      `CHK(s[ST_LOCK_BIT], 1'b0)
      `CHK(s[ST_REJ_BIT], 1'b1)
   endtask : t_lock

   task automatic t_otp();
      reboot(16'hfff7);
      cmd(CMD_PPB_PROGRAM, 8'd1);
      idle();
      cmd(CMD_PPB_ERASE, 8'd0);
      idle();
      `CHK(ppb_out[1], 1'b0)
      `CHK(s[ST_REJ_BIT], 1'b1)
   endtask : t_otp

   task automatic t_perm();
      reboot(16'hfffc);
      cmd(CMD_PPB_PROGRAM, 8'd2);
      idle();
      `CHK(ppb_out[2], 1'b1)
      wr(OFS_OPT_DATA, 32'h0);
      cmd(CMD_OPT_PROGRAM, 8'd0);
      wr(OFS_PWD_LO, 32'h0);
      cmd(CMD_PWD_PROGRAM, 8'd0);
      idle();
      `CHK(opt_out, 16'hfffc)
      `CHK(pwd_out, PW)
   endtask : t_perm

   task automatic t_pw();
      arr_resp_s r;
      reboot(16'hffdb);
      rd(OFS_STATUS);
      `CHK(s[2:1], 2'b10)
      arr(ACC_READ, 32'h1234, r);
      `CHK(r.addr, 32'h03fc_1234)
      arr(ACC_PROG, 32'h0, r);
      `CHK(r.grant, 1'b0)
      wr(OFS_OPT_DATA, 32'h0);
      cmd(CMD_OPT_PROGRAM, 8'd0);
      `CHK(opt_out, 16'hffdb)
      wr(OFS_KEY_LO, ~PW[31:0]);
      wr(OFS_KEY_HI, PW[63:32]);
      cmd(CMD_UNLOCK, 8'd0);
      rd(OFS_STATUS);
      `CHK({s[ST_FAIL_BIT], s[2:1]}, 3'b110)
      cmd(CMD_ERR_CLEAR, 8'd0);
      rd(OFS_STATUS);
      `CHK(s[4:3], 2'b00)
      wr(OFS_KEY_LO, PW[31:0]);
      cmd(CMD_UNLOCK, 8'd0);
      rd(OFS_STATUS);
      `CHK(s[2:1], 2'b01)
      rd(OFS_PWD_LO);
      `CHK(s, 32'h0)
      arr(ACC_READ, 32'h1234, r);
      `CHK(r.addr, 32'h1234)
   endtask : t_pw

   task automatic close_out();
      if (fails == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   // Main sequence
   initial
   begin
      reboot(OPT_RESET);
      t_lock();
      t_otp();
      t_perm();
      t_pw();
      close_out();
   end

   // Watchdog, well beyond the few hundred cycles the tests take
   initial
   begin
      #200000;
      fails++;
      close_out();
   end
endmodule : sector_protect_bench
